// ### bench/epd_host_model.sv
// host-side pulse counter: decodes quadrature and measures the index pulse
`timescale 1ns/1ps
module epd_host_model (
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic quadOutAPos,
    input  wire logic quadOutANeg,
    input  wire logic quadOutBPos,
    input  wire logic quadOutBNeg,
    input  wire logic indexOutPos,
    input  wire logic indexOutNeg,
    output int        stepCount,
    output int        pairErrs,
    output int        zCount,
    output int        zWidth,
    output int        zSyncErrs
);
    logic [1:0] prevIdx;
    logic       prevA;
    logic       prevZ;
    int         zRun;
    wire  [1:0] idx  = {quadOutAPos, quadOutAPos ^ quadOutBPos};
    wire  [1:0] diff = idx - prevIdx;
    initial begin
        stepCount = 0;
        pairErrs = 0;
        zCount = 0;
        zWidth = 0;
        zSyncErrs = 0;
    end
    // gray index 0..3; +1 means b leads, as a counter card counts up
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prevIdx <= 2'b00;
            prevA <= 1'b0;
            prevZ <= 1'b0;
            zRun <= 0;
        end else begin
            // a lost complement or a double step is a miscount downstream
            if (quadOutANeg !== ~quadOutAPos || quadOutBNeg !== ~quadOutBPos
                || indexOutNeg !== ~indexOutPos || diff == 2'd2) begin
                pairErrs <= pairErrs + 1;
            end else if (diff == 2'd1) begin
                stepCount <= stepCount + 1;
            end else if (diff == 2'd3) begin
                stepCount <= stepCount - 1;
            end
            prevIdx <= idx;
            prevA <= quadOutAPos;
            prevZ <= indexOutPos;
            zRun <= indexOutPos ? zRun + 1 : 0;
            if (prevZ && !indexOutPos) begin
                zWidth <= zRun;
                zCount <= zCount + 1;
            end
            if (indexOutPos != prevZ && (quadOutAPos == prevA || quadOutAPos != indexOutPos)) begin
                zSyncErrs <= zSyncErrs + 1;
            end
        end
    end
endmodule

// ### bench/tb_top.sv
// self-checking bench: settings, divided quadrature, index and reset
`timescale 1ns/1ps
module tb_top;
    import epd_pkg::*;
    localparam int ZCYC = 20;
    typedef struct {
        logic [31:0] ppr;
        logic [31:0] num;
        logic [31:0] den;
        logic        ph;
        int          steps;
        int          expOut;
        logic [31:0] stat;
    } epd_tb_row_t;
    logic        mclk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, quadOutAPos, quadOutANeg, quadOutBPos, quadOutBNeg;
    logic        indexOutPos, indexOutNeg, homeRef;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [23:0] encPos, homePos, ofs;
    int          errors, tests_run, stepCount, pairErrs, zCount, zWidth, zSyncErrs;
    int          homeCnt, s0, z0, h0, e0;
    epd_tb_row_t rows[6];

    epd_pulse_divider #(.Z_CYCLES(ZCYC)) dut_u (.*);
    epd_host_model host_u (.*);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (homeRef === 1'b1) begin
            homeCnt <= homeCnt + 1;
            homePos <= encPos;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRd(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        axiRd(a);
        check("rdata", exp, rd);
        check("rresp", {30'h0, er}, {30'h0, rs});
    endtask
    task automatic wrChk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
        axiWr(a, d);
        check("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
        rdChk(a, exp, RESP_OKAY);
    endtask
    // one base count per step, held long enough for the index path to settle
    task automatic move(input int n);
        repeat (n < 0 ? -n : n) begin
            encPos <= encPos + (n < 0 ? 24'hfffffc : 24'h000004);
            repeat (4) @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
    endtask
    task automatic cfg(input logic [31:0] p, n, d, input logic ph, input logic [31:0] o);
        axiWr(A_PPR, p);
        axiWr(A_NUM, n);
        axiWr(A_DEN, d);
        axiWr(A_PHASE, {31'h0, ph});
        axiWr(A_ZOFS, o);
        axiWr(A_CTRL, 32'h1);
        repeat (3) @(posedge mclk);
    endtask
    task automatic wrap_up;
        $display("checks run %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        wrap_up;
    end

    initial begin
        errors = 0;
        tests_run = 0;
        homeCnt = 0;
        arst_n = 1'b0;
        encPos = 24'h0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        // whole-step moves only: restart returns the phases to 00 without a jump
        rows[0] = '{32'h0, 32'h1, 32'h1, 1'b0, 8, 8, 32'h0};
        rows[1] = '{32'h0, 32'h1, 32'h4, 1'b0, 16, 4, 32'h0};
        rows[2] = '{32'h0, 32'h3, 32'h2, 1'b0, 8, 8, 32'h2};
        rows[3] = '{32'h0, 32'h1, 32'h1, 1'b1, 8, -8, 32'h0};
        rows[4] = '{32'h0, 32'h1, 32'h1, 1'b0, -8, -8, 32'h0};
        rows[5] = '{32'h400000, 32'h1, 32'h4, 1'b0, 8, 8, 32'h1};
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        rdChk(A_STAT, 32'h1, RESP_OKAY);
        foreach (rows[i]) begin
            cfg(rows[i].ppr, rows[i].num, rows[i].den, rows[i].ph, 32'h0);
            axiRd(A_STAT);
            check("mode", rows[i].stat, rd & 32'h3);
            s0 = stepCount;
            move(rows[i].steps);
            check("steps", rows[i].expOut, stepCount - s0);
        end
        wrChk(A_DEN, 32'h4000000, 32'h4000000);
        wrChk(A_DEN, 32'h4000001, 32'h4000000);
        wrChk(A_NUM, 32'h0, 32'h1);
        wrChk(A_PPR, 32'hf, 32'h400000);
        wrChk(A_PPR, 32'h400001, 32'h400000);
        wrChk(A_ZOFS, 32'hffffff, 32'hffffff);
        // byte strobes: only the low byte may change
        s_axi_wstrb <= 4'h1;
        wrChk(A_ZOFS, 32'h0, 32'hffff00);
        s_axi_wstrb <= 4'hf;
        axiWr(8'h1c, 32'h5);
        check("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        rdChk(8'h40, 32'h0, RESP_SLVERR);
        // staged ratio of 1/67108864 must not act before a restart
        axiWr(A_PPR, 32'h0);
        s0 = stepCount;
        move(8);
        check("staged only", 32'h8, stepCount - s0);
        ofs = encPos + 24'hc;
        cfg(32'h0, 32'h1, 32'h1, 1'b0, {8'h0, ofs});
        h0 = homeCnt;
        z0 = zCount;
        move(8);
        repeat (ZCYC) @(posedge mclk);
        check("home pulses", 32'h1, homeCnt - h0);
        check("home position", {8'h0, ofs}, {8'h0, homePos});
        check("index width", ZCYC, zWidth);
        check("index count", 32'h1, zCount - z0);
        cfg(32'h400000, 32'h1, 32'h1, 1'b0, {8'h0, ofs});
        h0 = homeCnt;
        z0 = zCount;
        e0 = zSyncErrs;
        move(-12);
        check("home reverse", 32'h1, homeCnt - h0);
        check("index seen", 32'h1, {31'h0, zCount > z0});
        check("index sync", 32'h0, zSyncErrs - e0);
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        check("outs in reset", 32'h2a, {25'h0, quadOutAPos, quadOutANeg, quadOutBPos,
            quadOutBNeg, indexOutPos, indexOutNeg, homeRef});
        arst_n <= 1'b1;
        rdChk(A_PPR, 32'h800, RESP_OKAY);
        rdChk(A_NUM, 32'h1, RESP_OKAY);
        rdChk(A_DEN, 32'h10, RESP_OKAY);
        rdChk(A_PHASE, 32'h0, RESP_OKAY);
        rdChk(A_ZOFS, 32'h0, RESP_OKAY);
        rdChk(A_CTRL, 32'h0, RESP_OKAY);
        rdChk(A_STAT, 32'h1, RESP_OKAY);
        check("pair faults", 32'h0, pairErrs);
        wrap_up;
    end
endmodule

// ### hdl/epd_pulse_divider.sv
// encoder emulation output: divided quadrature and index pulses, axi4-lite settings
//
// Functional notes
// R1 - numerator/denominator scale the output only while pulses-per-rev is zero.
// R2 - numerator and denominator accept 1..67108864, defaults 1 and 16.
// R3 - the ratio applies to a base count of encoder resolution less two bits.
// R4 - a numerator above the denominator gives a division ratio of exactly one.
// R5 - software should keep numerator no larger than denominator.
// R6 - in ratio mode the index pulse is free of the phases and 100 us wide.
// R7 - phase order at ccw: 0 makes B lead, 1 makes A lead, default 0.
// R8 - A and B leave on two complementary differential pairs.
// R9 - the index shifts ccw by an offset of 0..16777215 pulses, default 0.
// R10 - the index offset ignores the rotation direction selection.
// R11 - homing uses the same offset-shifted index position.
// R12 - in direct mode the index follows phase A with A's pulse width.
// R13 - pulses-per-rev accepts 16..4194304, zero selects the ratio.
// R14 - an accumulator adds the numerator per base count, steps at the denominator.
// R15 - settings take effect only at a restart.
`timescale 1ns/1ps
module epd_pulse_divider
    import epd_pkg::*;
#(
    parameter int Z_CYCLES = epd_pkg::Z_WIDTH_CYC
) (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [23:0] encPos,
    output logic             quadOutAPos,
    output logic             quadOutANeg,
    output logic             quadOutBPos,
    output logic             quadOutBNeg,
    output logic             indexOutPos,
    output logic             indexOutNeg,
    output logic             homeRef
);
    import epd_pkg::*;

    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        doWrite;
    logic        restart;
    logic [31:0] merged;
    epd_val_t    stPpr;
    epd_val_t    stNum;
    epd_val_t    stDen;
    logic        stPhase;
    logic [23:0] stZofs;
    epd_val_t    acPpr;
    epd_val_t    acNum;
    epd_val_t    acDen;
    logic        acPhase;
    logic [23:0] acZofs;
    logic        direct;
    logic        clamp;
    epd_val_t    effNum;
    epd_val_t    effDen;
    logic [21:0] prevBase;
    logic [21:0] delta;
    logic        encFwd;
    logic        encRev;
    epd_val_t    acc;
    logic [27:0] sumF;
    logic        stepUp;
    logic        stepDn;
    logic [1:0]  qCnt;
    logic [1:0]  gray;
    logic        aNext;
    logic        bNext;
    logic        zNext;
    logic [23:0] rel;
    logic        prevRelZero;
    logic        idxEvent;
    logic [14:0] zCnt;
    epd_zs_t     zs;
    epd_zs_t     next_zs;
    logic [2:0]  chVal;
    logic [2:0]  outP;
    logic [2:0]  outN;

    function automatic logic [31:0] regRead(input logic [7:0] a);
        case (a)
            A_PPR:   regRead = {5'h00, stPpr};
            A_NUM:   regRead = {5'h00, stNum};
            A_DEN:   regRead = {5'h00, stDen};
            A_PHASE: regRead = {31'h0, stPhase};
            A_ZOFS:  regRead = {8'h00, stZofs};
            A_STAT:  regRead = {27'h0, outP[2], outP[1], outP[0], clamp, direct};
            default: regRead = 32'h0;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= A_STAT) && (a[1:0] == 2'b00);
    endfunction

    // ---------------- axi4-lite write channel ----------------
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign doWrite       = awHeld && wHeld;

    always_comb begin
        merged = regRead(awAddr);
        for (int i = 0; i < 4; i++) begin
            if (wStrb[i]) begin
                merged[i*8 +: 8] = wData[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddr       <= 8'h00;
            wData        <= 32'h0;
            wStrb        <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // staged settings; out-of-range values are dropped, not clipped
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stPpr   <= RST_PPR;
            stNum   <= RST_NUM;
            stDen   <= RST_DEN;
            stPhase <= RST_PHASE;
            stZofs  <= RST_ZOFS;
        end else if (doWrite) begin
            case (awAddr)
                A_PPR: begin
                    if (merged[31:27] == 5'h00 && (merged[26:0] == 27'h0
                        || (merged[26:0] >= PPR_MIN && merged[26:0] <= PPR_MAX))) begin // R13
                        stPpr <= merged[26:0];
                    end
                end
                A_NUM: begin
                    if (merged[31:27] == 5'h00 && merged[26:0] != 27'h0
                        && merged[26:0] <= RATIO_MAX) begin // R2
                        stNum <= merged[26:0];
                    end
                end
                A_DEN: begin
                    if (merged[31:27] == 5'h00 && merged[26:0] != 27'h0
                        && merged[26:0] <= RATIO_MAX) begin // R2
                        stDen <= merged[26:0];
                    end
                end
                A_PHASE: stPhase <= merged[0];
                A_ZOFS:  stZofs  <= merged[23:0]; // R9
                default: ;
            endcase
        end
    end

    // restart emulates power-up: only then do staged values go live
    assign restart = doWrite && (awAddr == A_CTRL) && wStrb[0] && wData[CTRL_RESTART];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            acPpr   <= RST_PPR;
            acNum   <= RST_NUM;
            acDen   <= RST_DEN;
            acPhase <= RST_PHASE;
            acZofs  <= RST_ZOFS;
        end else if (restart) begin // R15
            acPpr   <= stPpr;
            acNum   <= stNum;
            acDen   <= stDen;
            acPhase <= stPhase;
            acZofs  <= stZofs;
        end
    end

    // ---------------- axi4-lite read channel ----------------
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= regRead(s_axi_araddr);
            s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- divider ----------------
    assign direct = (acPpr != 27'h0); // R1 R13
    assign clamp  = !direct && (acNum > acDen); // R4
    assign effNum = direct ? acPpr : (clamp ? 27'h1 : acNum); // R4 R5
    assign effDen = direct ? BASE_REV : (clamp ? 27'h1 : acDen);

    // base count drops the two low encoder bits; one base step per clock at most
    assign delta  = encPos[23:ENC_LSB] - prevBase; // R3
    assign encFwd = (delta == 22'h000001);
    assign encRev = (delta == 22'h3fffff);
    assign sumF   = {1'b0, acc} + {1'b0, effNum};
    assign stepUp = encFwd && (sumF >= {1'b0, effDen}); // R14
    assign stepDn = encRev && (acc < effNum); // R14

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prevBase <= 22'h0;
        end else begin
            prevBase <= encPos[23:ENC_LSB];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            acc  <= 27'h0;
            qCnt <= 2'b00;
        end else if (restart) begin
            acc  <= 27'h0;
            qCnt <= 2'b00;
        end else if (stepUp) begin // R14
            acc  <= 27'(sumF - {1'b0, effDen});
            qCnt <= qCnt + 2'b01;
        end else if (encFwd) begin
            acc  <= sumF[26:0];
        end else if (stepDn) begin // R14
            acc  <= acc + effDen - effNum;
            qCnt <= qCnt - 2'b01;
        end else if (encRev) begin
            acc  <= acc - effNum;
        end
    end

    // up-count is ccw; plain gray order lets B move first
    assign gray = {qCnt[1], qCnt[1] ^ qCnt[0]};
    assign {aNext, bNext} = acPhase ? {gray[0], gray[1]} : gray; // R7

    // ---------------- index ----------------
    // offset taken against raw position only, so direction setting never enters
    assign rel      = encPos - acZofs; // R9 R10
    assign idxEvent = (rel[23:ENC_LSB] == 22'h0) && !prevRelZero;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prevRelZero <= 1'b1;
            homeRef     <= 1'b0;
        end else begin
            prevRelZero <= (rel[23:ENC_LSB] == 22'h0);
            homeRef     <= idxEvent; // R11
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            zCnt <= 15'h0;
        end else if (restart || direct) begin
            zCnt <= 15'h0;
        end else if (idxEvent) begin
            zCnt <= 15'(Z_CYCLES); // R6
        end else if (zCnt != 15'h0) begin
            zCnt <= zCnt - 15'h1;
        end
    end

    always_comb begin
        next_zs = zs;
        case (zs)
            ZS_IDLE:  if (idxEvent && direct) next_zs = ZS_ARMED;
            ZS_ARMED: if (aNext && !outP[0]) next_zs = ZS_HIGH; // R12
            ZS_HIGH:  if (!aNext && outP[0]) next_zs = ZS_IDLE; // R12
            default:  next_zs = ZS_IDLE;
        endcase
        if (!direct || restart) begin
            next_zs = ZS_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            zs <= ZS_IDLE;
        end else begin
            zs <= next_zs;
        end
    end

    // a ratio-mode index is a timed pulse, unrelated to the phases
    assign zNext = direct ? (next_zs == ZS_HIGH) : (zCnt != 15'h0 && !restart); // R6 R12
    assign chVal = {zNext, bNext, aNext};

    // complementary pairs, each leg its own flop so both switch together
    for (genvar i = 0; i < 3; i++) begin : g_pair
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                outP[i] <= 1'b0;
                outN[i] <= 1'b1;
            end else begin
                outP[i] <= chVal[i]; // R8
                outN[i] <= !chVal[i]; // R8
            end
        end
    end

    assign quadOutAPos = outP[0];
    assign quadOutANeg = outN[0];
    assign quadOutBPos = outP[1];
    assign quadOutBNeg = outN[1];
    assign indexOutPos = outP[2];
    assign indexOutNeg = outN[2];

    // ---------------- checks ----------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_up_from0;
        stepUp && !restart && qCnt == 2'b00;
    endsequence

    a_ratio_clamp: assert property (clamp |-> effNum == 27'h1 && effDen == 27'h1) // R4
        else $error("ratio above one not clamped");
    a_direct_sel: assert property (direct |-> effNum == acPpr && effDen == BASE_REV) // R1
        else $error("direct mode ratio wrong");
    a_num_range: assert property (stNum != 27'h0 && stNum <= RATIO_MAX // R2
        && stDen != 27'h0 && stDen <= RATIO_MAX)
        else $error("ratio setting out of range");
    a_step_gray: assert property ((stepUp || stepDn) && !restart // R14
        |-> ##2 $countones({outP[0], outP[1]} ^ $past({outP[0], outP[1]})) == 1)
        else $error("step did not move one phase");
    a_b_leads: assert property ((s_up_from0 and !acPhase) |-> ##2 outP[1] && !outP[0]) // R7
        else $error("B did not lead at ccw");
    a_a_leads: assert property ((s_up_from0 and acPhase) |-> ##2 outP[0] && !outP[1]) // R7
        else $error("A did not lead at ccw");
    a_pair_compl: assert property (outN == ~outP) // R8
        else $error("differential legs not complementary");
    // the fall shows two edges after the counter's last nonzero value
    a_z_ratio_end: assert property ($fell(outP[2]) && !direct && !$past(restart) // R6
        |-> $past(zCnt, 2) == 15'h1)
        else $error("ratio index width wrong");
    a_z_ratio_hold: assert property (zCnt > 15'h1 && !direct && !restart |=> outP[2]) // R6
        else $error("ratio index dropped early");
    a_z_follows_a: assert property ($rose(outP[2]) && $past(direct) |-> $rose(outP[0])) // R12
        else $error("direct index not on A rise");
    a_z_fall_a: assert property ($fell(outP[2]) && $past(direct) && direct && !$past(restart) // R12
        |-> $fell(outP[0]))
        else $error("direct index width differs from A");
    // window entry, recomputed from the raw offset rather than from rel
    a_index_pos: assert property (idxEvent |-> encPos - acZofs < 24'h4 // R9
        && !$past(encPos - acZofs < 24'h4))
        else $error("index at wrong position");
    a_home_ref: assert property (idxEvent |=> homeRef) // R11
        else $error("home reference missed index");
    a_hold_cfg: assert property (!restart |=> $stable(acNum) && $stable(acPpr) // R15
        && $stable(acZofs))
        else $error("setting changed without restart");
endmodule

// ### shared/epd_pkg.sv
// constants and types for the encoder pulse output divider
package epd_pkg;
    typedef logic [26:0] epd_val_t;
    typedef enum logic [2:0] {
        ZS_IDLE  = 3'b001,
        ZS_ARMED = 3'b010,
        ZS_HIGH  = 3'b100
    } epd_zs_t;
    // register byte addresses
    localparam logic [7:0] A_PPR   = 8'h00;
    localparam logic [7:0] A_NUM   = 8'h04;
    localparam logic [7:0] A_DEN   = 8'h08;
    localparam logic [7:0] A_PHASE = 8'h0c;
    localparam logic [7:0] A_ZOFS  = 8'h10;
    localparam logic [7:0] A_CTRL  = 8'h14;
    localparam logic [7:0] A_STAT  = 8'h18;
    // reset values
    localparam epd_val_t RST_PPR   = 27'h0000800;
    localparam epd_val_t RST_NUM   = 27'h0000001;
    localparam epd_val_t RST_DEN   = 27'h0000010;
    localparam logic     RST_PHASE = 1'b0;
    localparam logic [23:0] RST_ZOFS = 24'h000000;
    // setting limits
    localparam epd_val_t RATIO_MAX = 27'h4000000;
    localparam epd_val_t PPR_MIN   = 27'h0000010;
    localparam epd_val_t PPR_MAX   = 27'h0400000;
    localparam epd_val_t BASE_REV  = 27'h0400000;
    // field positions
    localparam int CTRL_RESTART = 0;
    localparam int ST_DIRECT    = 0;
    localparam int ST_CLAMP     = 1;
    localparam int ST_A         = 2;
    localparam int ST_B         = 3;
    localparam int ST_Z         = 4;
    localparam int ENC_LSB      = 2;
    // timing and axi response codes
    localparam int CLK_MHZ      = 200;
    localparam int Z_WIDTH_US   = 100;
    localparam int Z_WIDTH_CYC  = Z_WIDTH_US * CLK_MHZ;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
